/* common/gpcfg_defines.vh */
// constants for the three-port general purpose pin block
`ifndef GPCFG_DEFINES_VH
`define GPCFG_DEFINES_VH
// register word addresses, port base is port index times port stride
`define GPCFG_PORT_STRIDE   8'h10
`define GPCFG_OFS_MODE_LOW  8'h00
`define GPCFG_OFS_MODE_HIGH 8'h01
`define GPCFG_OFS_IN_LEVEL  8'h02
`define GPCFG_OFS_OUT_LEVEL 8'h03
`define GPCFG_OFS_OUT_SET   8'h04
`define GPCFG_OFS_OUT_CLEAR 8'h05
`define GPCFG_OFS_WAKE_MASK 8'h06
`define GPCFG_OFS_DBG_CTRL  8'h30
`define GPCFG_OFS_DBG_STAT  8'h31
`define GPCFG_OFS_TIM2_OPT  8'h32
`define GPCFG_OFS_TIM2_EN   8'h33
`define GPCFG_OFS_ALT_SEL   8'h34
`define GPCFG_OFS_SLEEP     8'h35
// debug control fields
`define GPCFG_DBG_REGEN_BIT 0
`define GPCFG_DBG_OFF_BIT   1
`define GPCFG_DBG_RESET     2'h1
// timer 2 routing option bits
`define GPCFG_T2_ROUTE_LSB  4
// pin mode encodings
`define GPCFG_MODE_ANALOG   4'h0
`define GPCFG_MODE_OUT_PP   4'h1
`define GPCFG_MODE_IN_FLOAT 4'h4
`define GPCFG_MODE_OUT_OD   4'h5
`define GPCFG_MODE_IN_PULL  4'h8
`define GPCFG_MODE_ALT_PP   4'h9
`define GPCFG_MODE_ALT_SCLK 4'hb
`define GPCFG_MODE_ALT_OD   4'hd
`define GPCFG_MODE_RESET    32'h44444444
// boot hold time in oscillator periods
`define GPCFG_BOOT_HOLD     512
`endif

/* hw/gpcfg_top.v */
// three-port general purpose pin configuration and control block
//
// Contract
// - 24 pins in three ports of eight; register bits 7..0 map pins.
// - input register returns sampled pin levels except analog pins.
// - output register drives pins; clear and set writes modify bits.
// - wake mask selects pins watched for waking from sleep.
// - 4-bit mode per pin; low register pins 3..0, high 7..4.
// - mode 0x0 is analog; its input bit always reads one.
// - 0x4 floating input, 0x8 pulled input; output bit picks pull direction.
// - 0x1 push-pull, 0x5 open-drain output following output register bit.
// - 0x9 peripheral push-pull, 0xD peripheral open-drain, 0xB clock push-pull.
// - extra select registers choose among two alternate output sources.
// - enabled timer 2 channel outranks serial controller output.
// - timer 2 option bits 4..7 route channels to port A or B.
// - PA4/PA5 alternate carry packet trace or processor trace bits.
// - alternate mode with no peripheral drives constant zero.
// - debugger disable makes PC0, PC2, PC3, PC4 ordinary pins.
// - regulator enable forces PA7 open-drain carrying regulator enable.
// - JTAG active forces PC0, PC3, PC4 pulled-up inputs, PC2 push-pull.
// - serial wire active makes PC4 bidirectional under debugger control.
// - full chip reset sets every pin mode to floating input.
// - full chip reset sets regulator enable, clears debugger disable.
// - pin or always-on reset holds PA5 pulled up 512 oscillator periods.
// - after hold sample PA5 into boot status, then release it.
// - input and analog modes disable the driver; one source drives.
// - in sleep a masked pin change against entry value wakes.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "gpcfg_defines.vh"
module gpcfg_top #(
  parameter          NPORT     = 3,
  parameter          BOOT_HOLD = `GPCFG_BOOT_HOLD
) (
  input  wire        MCLK_IN,
  input  wire        SYS_RST_IN,
  input  wire        BOOT_RST_IN,
  input  wire        HFRC_TICK_IN,
  input  wire [7:0]  ADDR_IN,
  input  wire [31:0] WDATA_IN,
  input  wire        WR_IN,
  input  wire        RD_IN,
  output reg  [31:0] RDATA_OUT,
  input  wire [23:0] PIN_IN,
  output reg  [23:0] PIN_OUT,
  output reg  [23:0] PIN_OE_OUT,
  output reg  [23:0] PULL_UP_OUT,
  output reg  [23:0] PULL_DOWN_OUT,
  input  wire [3:0]  TIM2_CH_IN,
  input  wire [23:0] SERIAL_ALT_IN,
  input  wire [1:0]  PKT_TRACE_IN,
  input  wire [1:0]  CPU_TRACE_IN,
  input  wire        REG_EN_IN,
  input  wire        DBG_JTAG_IN,
  input  wire        DBG_SW_IN,
  input  wire        TEST_DATA_OUT_IN,
  input  wire        SW_DATA_IN,
  input  wire        SW_DATA_OE_IN,
  output reg  [23:0] PIN_LEVEL_OUT,
  output reg         BOOT_LOADER_OUT,
  output reg         WAKE_OUT
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  // output driver enabled for a mode
  function mode_drives;
    input [3:0] m;
    begin
      mode_drives = (m == `GPCFG_MODE_OUT_PP) || (m == `GPCFG_MODE_OUT_OD) ||
                    (m == `GPCFG_MODE_ALT_PP) || (m == `GPCFG_MODE_ALT_OD) ||
                    (m == `GPCFG_MODE_ALT_SCLK);
    end
  endfunction

  // alternate source for a mode
  function mode_alt;
    input [3:0] m;
    begin
      mode_alt = (m == `GPCFG_MODE_ALT_PP) || (m == `GPCFG_MODE_ALT_OD) ||
                 (m == `GPCFG_MODE_ALT_SCLK);
    end
  endfunction

  // open drain for a mode
  function mode_od;
    input [3:0] m;
    begin
      mode_od = (m == `GPCFG_MODE_OUT_OD) || (m == `GPCFG_MODE_ALT_OD);
    end
  endfunction

  // ************************************************************
  // register state
  // ************************************************************
  reg  [95:0] pin_mode_field;  // 4 bits per pin, pin 0 lowest
  reg  [23:0] port_output_level;
  reg  [23:0] port_wake_mask;
  reg  [1:0]  debug_pin_control;
  reg  [7:0]  timer2_route_option;
  reg  [3:0]  timer2_channel_enable;
  reg         trace_sel;       // 1 selects processor trace on PA4/PA5
  reg         sleep_req;
  reg  [23:0] sleep_snap;
  reg         asleep;
  reg         boot_hold;
  reg  [9:0]  boot_cnt;
  reg         boot_select_capture;
  reg         boot_rst_d;      // set on first edge if a pin or always-on reset; ticks then count while boot_hold is set

  wire        ext_regulator_enable = debug_pin_control[`GPCFG_DBG_REGEN_BIT];
  wire        debugger_off_bit     = debug_pin_control[`GPCFG_DBG_OFF_BIT];
  wire [1:0]  port_sel = ADDR_IN[5:4];
  wire [3:0]  reg_sel  = ADDR_IN[3:0];
  wire        port_hit = (port_sel < NPORT) && (ADDR_IN[7:6] == 2'h0);
  wire [4:0]  pbase    = {port_sel, 3'h0};

  // ************************************************************
  // register writes
  // ************************************************************
  // mode reset
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pin_mode_field        <= {`GPCFG_MODE_RESET, `GPCFG_MODE_RESET, `GPCFG_MODE_RESET};
      port_output_level     <= 24'h000000;
      port_wake_mask        <= 24'h000000;
      debug_pin_control     <= `GPCFG_DBG_RESET;
      timer2_route_option   <= 8'h00;
      timer2_channel_enable <= 4'h0;
      trace_sel             <= 1'b0;
      sleep_req             <= 1'b0;
    end else if (WR_IN) begin
      if (port_hit) begin
        case (reg_sel)
          `GPCFG_OFS_MODE_LOW: pin_mode_field[pbase*4 +: 16] <= WDATA_IN[15:0];
          `GPCFG_OFS_MODE_HIGH: pin_mode_field[pbase*4 + 16 +: 16] <= WDATA_IN[15:0];
          `GPCFG_OFS_OUT_LEVEL: port_output_level[pbase +: 8] <= WDATA_IN[7:0];
          `GPCFG_OFS_OUT_SET: port_output_level[pbase +: 8] <= port_output_level[pbase +: 8] | WDATA_IN[7:0];
          `GPCFG_OFS_OUT_CLEAR: port_output_level[pbase +: 8] <= port_output_level[pbase +: 8] & ~WDATA_IN[7:0];
          `GPCFG_OFS_WAKE_MASK: port_wake_mask[pbase +: 8] <= WDATA_IN[7:0];
          default: ;
        endcase
      end else begin
        case (ADDR_IN)
          `GPCFG_OFS_DBG_CTRL: debug_pin_control <= WDATA_IN[1:0];
          `GPCFG_OFS_TIM2_OPT: timer2_route_option <= WDATA_IN[7:0];
          `GPCFG_OFS_TIM2_EN: timer2_channel_enable <= WDATA_IN[3:0];
          `GPCFG_OFS_ALT_SEL: trace_sel <= WDATA_IN[0];
          `GPCFG_OFS_SLEEP: sleep_req <= WDATA_IN[0];
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // input sampling
  // ************************************************************
  // analog pins read one
  reg [23:0] in_level;
  integer    k;
  always @* begin
    in_level = PIN_IN;
    for (k = 0; k < 24; k = k + 1) begin
      if (pin_mode_field[k*4 +: 4] == `GPCFG_MODE_ANALOG) begin
        in_level[k] = 1'b1;
      end
    end
  end

  // ************************************************************
  // alternate output sources
  // ************************************************************
  // timer 2 routing over serial outputs
  // source select, unassigned pins drive zero
  reg [23:0] alt_val;
  reg [23:0] alt_has;
  integer    c;
  always @* begin
    alt_val = SERIAL_ALT_IN;
    alt_has = 24'h000000;
    alt_has[1] = 1'b1; alt_has[2] = 1'b1; alt_has[3] = 1'b1;
    alt_has[8+1] = 1'b1; alt_has[8+2] = 1'b1; alt_has[8+3] = 1'b1; alt_has[8+4] = 1'b1;
    alt_has[4] = 1'b1; alt_has[5] = 1'b1;
    alt_val[4] = trace_sel ? CPU_TRACE_IN[0] : PKT_TRACE_IN[0];
    alt_val[5] = trace_sel ? CPU_TRACE_IN[1] : PKT_TRACE_IN[1];
    for (c = 0; c < 4; c = c + 1) begin
      if (timer2_channel_enable[c]) begin
        if (timer2_route_option[`GPCFG_T2_ROUTE_LSB + c]) begin
          alt_val[9 + c] = TIM2_CH_IN[c];
          alt_has[9 + c] = 1'b1;
        end else begin
          case (c)
            0: begin alt_val[0] = TIM2_CH_IN[0]; alt_has[0] = 1'b1; end
            1: alt_val[3] = TIM2_CH_IN[1];
            2: alt_val[1] = TIM2_CH_IN[2];
            default: alt_val[2] = TIM2_CH_IN[3];
          endcase
        end
      end
    end
    alt_val = alt_val & alt_has;
  end

  // ************************************************************
  // pin driver decode
  // ************************************************************
  reg [23:0] next_out;
  reg [23:0] next_oe;
  reg [23:0] next_pu;
  reg [23:0] next_pd;
  reg [3:0]  m;
  reg        v;
  integer    p;
  always @* begin
    next_out = 24'h000000;
    next_oe  = 24'h000000;
    next_pu  = 24'h000000;
    next_pd  = 24'h000000;
    m = 4'h0;
    v = 1'b0;
    for (p = 0; p < 24; p = p + 1) begin
      m = pin_mode_field[p*4 +: 4];
      v = mode_alt(m) ? alt_val[p] : port_output_level[p];
      // driver only in output modes; open drain drives low only
      if (mode_drives(m)) begin
        next_oe[p]  = mode_od(m) ? ~v : 1'b1;
        next_out[p] = mode_od(m) ? 1'b0 : v;
      end
      if (m == `GPCFG_MODE_IN_PULL) begin
        next_pu[p] = port_output_level[p];
        next_pd[p] = ~port_output_level[p];
      end
    end
    if (boot_hold) begin
      next_oe[5] = 1'b0; next_out[5] = 1'b0; next_pu[5] = 1'b1; next_pd[5] = 1'b0;
    end
    if (ext_regulator_enable) begin
      next_oe[7] = ~REG_EN_IN; next_out[7] = 1'b0; next_pu[7] = 1'b0; next_pd[7] = 1'b0;
    end
    if (!debugger_off_bit && DBG_JTAG_IN) begin
      next_oe[16] = 1'b0; next_pu[16] = 1'b1; next_pd[16] = 1'b0;
      next_oe[19] = 1'b0; next_pu[19] = 1'b1; next_pd[19] = 1'b0;
      next_oe[20] = 1'b0; next_pu[20] = 1'b1; next_pd[20] = 1'b0;
      next_oe[18] = 1'b1; next_out[18] = TEST_DATA_OUT_IN; next_pu[18] = 1'b0; next_pd[18] = 1'b0;
    end else if (!debugger_off_bit && DBG_SW_IN) begin
      next_oe[20] = SW_DATA_OE_IN; next_out[20] = SW_DATA_IN; next_pu[20] = 1'b0; next_pd[20] = 1'b0;
    end
  end

  // ************************************************************
  // boot select hold and capture
  // ************************************************************
  // hold count on oscillator ticks
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      boot_hold           <= 1'b1;
      boot_cnt            <= 10'h000;
      boot_select_capture <= 1'b0;
      boot_rst_d          <= 1'b0;
    end else begin
      if (boot_hold && !boot_rst_d) begin
        // first edge after release: hold only after a pin or always-on reset
        boot_rst_d <= BOOT_RST_IN;
        boot_hold  <= BOOT_RST_IN;
      end else if (boot_hold && HFRC_TICK_IN) begin
        if (boot_cnt == BOOT_HOLD - 1) begin
          boot_hold           <= 1'b0;
          boot_select_capture <= ~PIN_IN[5];
        end else begin
          boot_cnt <= boot_cnt + 10'h001;
        end
      end
    end
  end

  // ************************************************************
  // sleep wake detection
  // ************************************************************
  // masked change against entry snapshot
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      asleep     <= 1'b0;
      sleep_snap <= 24'h000000;
      WAKE_OUT   <= 1'b0;
    end else begin
      asleep <= sleep_req;
      if (sleep_req && !asleep) begin
        sleep_snap <= in_level;
      end
      WAKE_OUT <= asleep && sleep_req && (|((in_level ^ sleep_snap) & port_wake_mask));
    end
  end

  // ************************************************************
  // registered outputs and read data
  // ************************************************************
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PIN_OUT         <= 24'h000000;
      PIN_OE_OUT      <= 24'h000000;
      PULL_UP_OUT     <= 24'h000000;
      PULL_DOWN_OUT   <= 24'h000000;
      PIN_LEVEL_OUT   <= 24'hffffff;
      BOOT_LOADER_OUT <= 1'b0;
      RDATA_OUT       <= 32'h00000000;
    end else begin
      PIN_OUT         <= next_out;
      PIN_OE_OUT      <= next_oe;
      PULL_UP_OUT     <= next_pu;
      PULL_DOWN_OUT   <= next_pd;
      PIN_LEVEL_OUT   <= in_level;
      BOOT_LOADER_OUT <= boot_select_capture;
      RDATA_OUT       <= 32'h00000000;
      if (RD_IN) begin
        if (port_hit) begin
          case (reg_sel)
            `GPCFG_OFS_MODE_LOW: RDATA_OUT <= {16'h0000, pin_mode_field[pbase*4 +: 16]};
            `GPCFG_OFS_MODE_HIGH: RDATA_OUT <= {16'h0000, pin_mode_field[pbase*4 + 16 +: 16]};
            `GPCFG_OFS_IN_LEVEL: RDATA_OUT <= {24'h000000, in_level[pbase +: 8]};
            `GPCFG_OFS_OUT_LEVEL: RDATA_OUT <= {24'h000000, port_output_level[pbase +: 8]};
            `GPCFG_OFS_WAKE_MASK: RDATA_OUT <= {24'h000000, port_wake_mask[pbase +: 8]};
            default: RDATA_OUT <= 32'h00000000;
          endcase
        end else begin
          case (ADDR_IN)
            `GPCFG_OFS_DBG_CTRL: RDATA_OUT <= {30'h00000000, debug_pin_control};
            `GPCFG_OFS_DBG_STAT: RDATA_OUT <= {31'h00000000, ~boot_select_capture};
            `GPCFG_OFS_TIM2_OPT: RDATA_OUT <= {24'h000000, timer2_route_option};
            `GPCFG_OFS_TIM2_EN: RDATA_OUT <= {28'h0000000, timer2_channel_enable};
            `GPCFG_OFS_ALT_SEL: RDATA_OUT <= {31'h00000000, trace_sel};
            `GPCFG_OFS_SLEEP: RDATA_OUT <= {31'h00000000, sleep_req};
            default: RDATA_OUT <= 32'h00000000;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

/* tb/gpcfg_pin_model.sv */
// model of the package pins and what hangs on them
`timescale 1ns/100ps
`default_nettype none
module gpcfg_pin_model (
  input  wire logic [23:0] out_in,
  input  wire logic [23:0] oe_in,
  input  wire logic [23:0] pu_in,
  input  wire logic [23:0] pd_in,
  input  wire logic [23:0] ext_en_in,
  input  wire logic [23:0] ext_in,
  output logic      [23:0] level_out
);
  // ****************************************
  // wire level resolution
  // ****************************************
  // block driver wins, then outside source, then pulls; a bare line reads inverted
  always_comb begin
    for (int i = 0; i < 24; i++)
      level_out[i] = oe_in[i] ? out_in[i] : ext_en_in[i] ? ext_in[i] : pu_in[i] | (!pd_in[i] & !ext_in[i]);
  end
endmodule
`default_nettype wire

/* tb/gpcfg_properties.sv */
// port assertions for the pin configuration block
`timescale 1ns/100ps
`default_nettype none
module gpcfg_props (
  input wire logic        MCLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic [23:0] PIN_OUT,
  input wire logic [23:0] PIN_OE_OUT,
  input wire logic [23:0] PULL_UP_OUT,
  input wire logic [23:0] PULL_DOWN_OUT,
  input wire logic        REG_EN_IN,
  input wire logic        DBG_JTAG_IN,
  input wire logic        DBG_SW_IN,
  input wire logic        TEST_DATA_OUT_IN,
  input wire logic        SW_DATA_IN,
  input wire logic        SW_DATA_OE_IN
);
  // ****************************************
  // debug control mirror and properties
  // ****************************************
  logic [1:0] dbg;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // [1] debugger off, [0] regulator force
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    if (SYS_RST_IN) dbg <= 2'h1;
    else if (WR_IN && ADDR_IN == 8'h30) dbg <= WDATA_IN[1:0];
  property p_reg_force;
    !$past(SYS_RST_IN) && $past(dbg[0]) |-> PIN_OE_OUT[7] == !$past(REG_EN_IN) && !PIN_OUT[7];
  endproperty
  a_reg_force: assert property (p_reg_force) else $error("regulator pin not open drain");
  property p_jtag_in;
    !$past(SYS_RST_IN) && $past(DBG_JTAG_IN && !DBG_SW_IN && !dbg[1]) |->
      PULL_UP_OUT[20:19] == 2'h3 && PULL_UP_OUT[16] && !PIN_OE_OUT[16];
  endproperty
  a_jtag_in: assert property (p_jtag_in) else $error("jtag inputs not pulled up");
  property p_jtag_out;
    !$past(SYS_RST_IN) && $past(DBG_JTAG_IN && !DBG_SW_IN && !dbg[1]) |->
      PIN_OE_OUT[18] && PIN_OUT[18] == $past(TEST_DATA_OUT_IN);
  endproperty
  a_jtag_out: assert property (p_jtag_out) else $error("jtag data out not driven");
  property p_swd;
    !$past(SYS_RST_IN) && $past(DBG_SW_IN && !DBG_JTAG_IN && !dbg[1]) |->
      PIN_OE_OUT[20] == $past(SW_DATA_OE_IN) && (!PIN_OE_OUT[20] || PIN_OUT[20] == $past(SW_DATA_IN));
  endproperty
  a_swd: assert property (p_swd) else $error("serial wire pin wrong");
  property p_rst_modes;
    $past(SYS_RST_IN) |=> (PIN_OE_OUT & 24'he2ff7f) == 24'h0 && PULL_DOWN_OUT == 24'h0;
  endproperty
  a_rst_modes: assert property (p_rst_modes) else $error("pins not floating after reset");
  property p_rst_reg;
    $past(SYS_RST_IN) |=> PIN_OE_OUT[7] == !$past(REG_EN_IN);
  endproperty
  a_rst_reg: assert property (p_rst_reg) else $error("regulator force lost at reset");
  property p_pull_excl;
    (PULL_UP_OUT & PULL_DOWN_OUT) == 24'h0;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
  property p_drv_no_pull;
    (PIN_OE_OUT & (PULL_UP_OUT | PULL_DOWN_OUT)) == 24'h0;
  endproperty
  a_drv_no_pull: assert property (p_drv_no_pull) else $error("pull active on driven pin");
endmodule
bind gpcfg_top gpcfg_props gpcfg_props_inst (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PULL_UP_OUT(PULL_UP_OUT),
  .PULL_DOWN_OUT(PULL_DOWN_OUT), .REG_EN_IN(REG_EN_IN), .DBG_JTAG_IN(DBG_JTAG_IN), .DBG_SW_IN(DBG_SW_IN),
  .TEST_DATA_OUT_IN(TEST_DATA_OUT_IN), .SW_DATA_IN(SW_DATA_IN), .SW_DATA_OE_IN(SW_DATA_OE_IN));
`default_nettype wire

/* tb/test_gpio_port_config_block.sv */
// self-checking bench for the pin configuration block
`timescale 1ns/100ps
`default_nettype none
module test_gpio_port_config_block;
  typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} gpcfg_row_t;
  logic        clk = 0, rst = 1, brst = 0, tick = 0, wr = 0, rd = 0;
  logic        reg_en = 1, jtag = 0, sw = 0, tdo = 0, swd = 0, swoe = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [3:0]  tim = 4'h0;
  logic [1:0]  pkt = 2'h0, cpu = 2'h0;
  logic [23:0] ser = 24'h0, ext = 24'h5a3c96, ext_en = 24'hffffff;
  wire  [31:0] rdata;
  wire  [23:0] pin_in, pin_out, oe, pu, pd, lvl;
  wire         boot_ldr, wake;
  int          bad_count = 0, compares = 0;
  int          pa_map [4] = '{0, 3, 1, 2};
  logic [3:0]  modes [8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hd, 4'hb};
  logic [3:0]  exps [8] = '{4'h0, 4'h0, 4'h2, 4'hc, 4'h0, 4'h8, 4'h8, 4'h8};
  gpcfg_row_t  rows [7] = '{'{8'h0f, 32'hff, 8'h0f, 32'h0}, '{8'h00, 32'h1111, 8'h12, 32'h3c},
    '{8'h03, 32'ha5, 8'h00, 32'h1111}, '{8'h04, 32'h0a, 8'h03, 32'haf}, '{8'h05, 32'h21, 8'h03, 32'h8e},
    '{8'h26, 32'h3c, 8'h24, 32'h0}, '{8'h11, 32'h0584, 8'h26, 32'h3c}};
  gpcfg_top #(.BOOT_HOLD(4)) gpcfg_top_inst (
    .MCLK_IN(clk), .SYS_RST_IN(rst), .BOOT_RST_IN(brst), .HFRC_TICK_IN(tick), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_OUT(oe), .PULL_UP_OUT(pu), .PULL_DOWN_OUT(pd), .TIM2_CH_IN(tim), .SERIAL_ALT_IN(ser),
    .PKT_TRACE_IN(pkt), .CPU_TRACE_IN(cpu), .REG_EN_IN(reg_en), .DBG_JTAG_IN(jtag), .DBG_SW_IN(sw),
    .TEST_DATA_OUT_IN(tdo), .SW_DATA_IN(swd), .SW_DATA_OE_IN(swoe), .PIN_LEVEL_OUT(lvl),
    .BOOT_LOADER_OUT(boot_ldr), .WAKE_OUT(wake));
  gpcfg_pin_model gpcfg_pin_model_inst (.out_in(pin_out), .oe_in(oe), .pu_in(pu), .pd_in(pd),
    .ext_en_in(ext_en), .ext_in(ext), .level_out(pin_in));
  // ****************************************
  // clock, oscillator ticks and bus tasks
  // ****************************************
  always #4 clk = ~clk;
  always @(posedge clk) tick <= ~tick;
  task automatic rst_run;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_run();
    for (int p = 0; p < 3; p++) begin
      rreg(8'(p * 16), d);
      chk("mode low", 32'h4444, d);
      rreg(8'(p * 16 + 1), d);
      chk("mode high", 32'h4444, d);
    end
    rreg(8'h30, d);
    chk("debug ctrl", 32'h1, d);
    @(posedge clk) #1;
    chk("rdata idle", 32'h0, rdata);
    foreach (rows[i]) begin
      wreg(rows[i].wa, rows[i].wd);
      rreg(rows[i].ra, d);
      chk("row", rows[i].ex, d);
    end
    settle();
    chk("pa outputs", 32'hfe, {24'h0, oe[3:0], pin_out[3:0]});
    rreg(8'h02, d);
    chk("pa input", 32'h9e, d);
    chk("levels", 32'hbc9e, {16'h0, lvl[15:0]});
    chk("pb5 pull down", 32'h1, {31'h0, pd[13]});
    // every mode on a pin without a peripheral
    wreg(8'h13, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wreg(8'h10, {28'h0, modes[i]});
      settle();
      chk("pb0 pins", {28'h0, exps[i]}, {28'h0, oe[8], pin_out[8] & oe[8], pu[8], pd[8]});
      rreg(8'h12, d);
      if (i < 2) chk("pb0 input", {31'h0, i == 0}, {31'h0, d[0]});
    end
    // timer routing and priority over serial
    wreg(8'h00, 32'h9999);
    wreg(8'h10, 32'h9990);
    wreg(8'h11, 32'h9);
    wreg(8'h33, 32'hf);
    for (int i = 0; i < 8; i++) begin
      wreg(8'h32, i[2] ? 32'hf0 : 32'h0);
      tim <= 4'h1 << i[1:0];
      settle();
      chk("timer route", i[2] ? {24'h0, 4'h1 << i[1:0], 4'h0} : {28'h0, 4'h1 << pa_map[i[1:0]]},
        {24'h0, pin_out[12:9], pin_out[3:0]});
    end
    @(posedge clk);
    tim <= 4'h0;
    ser <= 24'hffffff;
    settle();
    chk("timer over serial", 32'h0e, {24'h0, pin_out[12:9], pin_out[3:0]});
    wreg(8'h33, 32'h0);
    settle();
    chk("serial alone", 32'hfe, {24'h0, pin_out[12:9], pin_out[3:0]});
    // trace source select on PA4 and PA5
    wreg(8'h01, 32'h99);
    pkt <= 2'h2;
    cpu <= 2'h1;
    for (int s = 0; s < 2; s++) begin
      wreg(8'h34, 32'(s));
      settle();
      chk("trace", 32'(2 - s), {30'h0, pin_out[5:4]});
    end
    // sleep entry snapshot and masked wake on port C
    wreg(8'h35, 32'h1);
    settle();
    @(posedge clk);
    ext[16] <= ~ext[16];
    settle();
    chk("wake unmasked", 32'h0, {31'h0, wake});
    @(posedge clk);
    ext[19] <= ~ext[19];
    settle();
    chk("wake masked", 32'h1, {31'h0, wake});
    wreg(8'h35, 32'h0);
    settle();
    chk("wake off", 32'h0, {31'h0, wake});
    // forced functions
    @(posedge clk);
    reg_en <= 1'b0;
    jtag <= 1'b1;
    tdo <= 1'b1;
    settle();
    chk("forced pins", 32'h3, {30'h0, oe[7], oe[18]});
    wreg(8'h30, 32'h2);
    settle();
    chk("debug off", 32'h0, {21'h0, oe[7], oe[20:16], pu[20:16]});
    wreg(8'h30, 32'h1);
    jtag <= 1'b0;
    sw <= 1'b1;
    swd <= 1'b1;
    swoe <= 1'b1;
    settle();
    chk("sw drive", 32'h3, {30'h0, oe[20], pin_out[20]});
    @(posedge clk);
    swoe <= 1'b0;
    settle();
    chk("sw release", 32'h0, {31'h0, oe[20]});
    // boot pin hold and capture after a pin reset
    @(posedge clk);
    ext[5] <= 1'b0;
    brst <= 1'b1;
    rst_run();
    settle();
    chk("boot pull", 32'h1, {31'h0, pu[5]});
    for (int n = 0; n < 40 && pu[5] === 1'b1; n++) @(posedge clk) #1;
    chk("boot release", 32'h0, {31'h0, pu[5]});
    settle();
    chk("boot loader", 32'h1, {31'h0, boot_ldr});
    rreg(8'h31, d);
    chk("boot status", 32'h0, {31'h0, d[0]});
    print_verdict();
  end
endmodule
`default_nettype wire
